// ### pkg/ifc_pkg.sv
/*
  Shared constants and types for the digital input supervisor.
  Assumes a single clock domain and a plain register port.
*/
// Overview of operation
// - start allowed only while permissive closed
// - permissive lost while running: coast, not-enabled
// - stop follows sampled permissive, not direct path
// - any open permissive input blocks running
// - relay follows its linked input state
// - exclusive link inert; unused link non-functional
// - threshold input closed selects settable level
// - unassigned threshold select uses internal level
// - bus-connect open: precharge, relay open, coast
// - unassigned bus-connect means always connected
// - conflicts refuse start, clear automatically
// - conflict: not ready, panel message, flash yellow
// - all config writes accepted, conflicts flagged
// - alarm A ramp and jog pair conflicts
// - alarm A momentary start without stop-clear
// - alarm B start-mode pair conflicts
// - alarm C duplicated single-assignment functions
// - direction functions conflict with any non-terminal policy (bipolar or reverse-blocked)
// - bipolar uses sign; reverse-blocked never reverses
// - status word bit one per closed input
package ifc_pkg;

  // --------------------------------------------------------------
  // sizes and register map
  // --------------------------------------------------------------
  localparam int NUM_IN = 6;
  localparam int NUM_OUT = 3;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_IN_CFG0 = 4'h0; // inputs 0..3 funcs
  localparam logic [ADDR_W-1:0] REG_IN_CFG1 = 4'h1; // inputs 4..5 funcs
  localparam logic [ADDR_W-1:0] REG_OUT_SEL = 4'h2; // relay sources
  localparam logic [ADDR_W-1:0] REG_DIR_MODE = 4'h3;
  localparam logic [ADDR_W-1:0] REG_UV_LEVEL = 4'h4;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h5; // start/stop requests
  localparam logic [ADDR_W-1:0] REG_PIN_STATE = 4'h6;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h7;

  localparam int FUNC_W = 5;
  localparam int SEL_W = 5;
  localparam int BUS_W = 12;
  localparam logic [BUS_W-1:0] UV_RESET = 12'h000;
  // internal level: 82 percent of nominal bus code 12'hfff
  localparam logic [BUS_W-1:0] UV_INTERNAL = 12'hd1e;

  // ctrl bits
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_REV = 2;

  // status bits
  localparam int ST_RUN = 0;
  localparam int ST_READY = 1;
  localparam int ST_NOT_EN = 2;
  localparam int ST_CFA = 3;
  localparam int ST_CFB = 4;
  localparam int ST_CFC = 5;
  localparam int ST_BIP = 6;
  localparam int ST_PLOSS = 7;
  localparam int ST_PRECH = 8;
  localparam int ST_REV = 9;
  localparam int ST_W = 10;

  // --------------------------------------------------------------
  // input function codes
  // --------------------------------------------------------------
  typedef enum logic [FUNC_W-1:0] {
    FN_UNUSED, FN_ENABLE, FN_CLR_FAULT, FN_AUX_FAULT, FN_STOP_FCLR,
    FN_START, FN_FWD_REV, FN_RUN, FN_RUN_FWD, FN_RUN_REV, FN_JOG,
    FN_JOG_FWD, FN_JOG_REV, FN_STOP_B, FN_BUSREG_B, FN_SPD_SEL1,
    FN_SPD_SEL2, FN_SPD_SEL3, FN_ACC2, FN_DEC2, FN_PAIRED_RAMP,
    FN_EXCL_LINK, FN_UV_SEL, FN_BUS_CONN
  } ifc_func_type;

  // relay sources: 0 = status run, 1..6 input links
  localparam logic [SEL_W-1:0] SEL_RUN = 5'h00;
  localparam logic [SEL_W-1:0] SEL_LINK0 = 5'h01;

  typedef enum logic [1:0] {
    DIR_TERMINAL, DIR_BIPOLAR, DIR_REV_DIS
  } ifc_dir_type;

  typedef struct packed {
    logic general;
    logic start_mode;
    logic duplicate;
    logic bipolar;
  } ifc_alarm_type;

endpackage

// ### core/ifc_supervisor.sv
/*
  Digital input supervisor: permissives, relay links, undervoltage
  threshold select, bus-connect handling and conflict alarms.
  Assumes contact inputs are asynchronous and software drives a plain
  single-cycle register port on core_clk.
*/
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/100ps
module ifc_supervisor
  import ifc_pkg::*;
#(
  parameter int N_IN = NUM_IN
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [N_IN-1:0] pin_in,
  input wire logic [BUS_W-1:0] bus_level,
  input wire logic ref_negative,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic motor_run,
  output logic motor_rev,
  output logic coast_stop,
  output logic not_enabled,
  output logic drive_ready,
  output logic panel_conflict_msg,
  output logic led_flash_yellow,
  output logic power_loss,
  output logic precharge_relay,
  output logic [NUM_OUT-1:0] relay_out,
  output ifc_alarm_type alarm
);

  // ----------------------------------------------------------------
  // input synchroniser
  // ----------------------------------------------------------------
  logic [N_IN-1:0] pin_meta_q;
  logic [N_IN-1:0] pin_sync_q;

  // second stage alone feeds logic, metastability stays contained
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else begin
      pin_meta_q <= pin_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  ifc_func_type func_q [N_IN];
  logic [SEL_W-1:0] out_sel_q [NUM_OUT];
  ifc_dir_type dir_mode_q;
  logic [BUS_W-1:0] uv_level_q;
  // flat copy of the function table, read by the decode functions
  wire [N_IN*FUNC_W-1:0] func_flat;

  wire wr_cfg0 = reg_wr && (reg_addr == REG_IN_CFG0);
  wire wr_cfg1 = reg_wr && (reg_addr == REG_IN_CFG1);
  wire wr_osel = reg_wr && (reg_addr == REG_OUT_SEL);
  wire wr_dir = reg_wr && (reg_addr == REG_DIR_MODE);
  wire wr_uv = reg_wr && (reg_addr == REG_UV_LEVEL);
  wire wr_ctrl = reg_wr && (reg_addr == REG_CTRL);

  // every write lands regardless of consistency
  genvar gi;
  generate
    for (gi = 0; gi < N_IN; gi++) begin : g_func
      localparam int SLOT = gi % 4;
      wire wr_me = (gi < 4) ? wr_cfg0 : wr_cfg1;
      assign func_flat[gi*FUNC_W +: FUNC_W] = func_q[gi];
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          func_q[gi] <= FN_UNUSED;
        end else if (wr_me) begin
          func_q[gi] <= ifc_func_type'(reg_wdata[SLOT*8 +: FUNC_W]);
        end
      end
    end
    for (gi = 0; gi < NUM_OUT; gi++) begin : g_osel
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          out_sel_q[gi] <= SEL_RUN;
        end else if (wr_osel) begin
          out_sel_q[gi] <= reg_wdata[gi*8 +: SEL_W];
        end
      end
    end
  endgenerate

  // scalar configuration
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_mode_q <= DIR_TERMINAL;
      uv_level_q <= UV_RESET;
    end else begin
      if (wr_dir) begin
        dir_mode_q <= ifc_dir_type'(reg_wdata[1:0]);
      end
      if (wr_uv) begin
        uv_level_q <= reg_wdata[BUS_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // function decode
  // ----------------------------------------------------------------
  // mask of inputs that carry a given function; the table comes in as
  // an argument so every decoding assignment wakes up on a write
  function automatic logic [N_IN-1:0] fn_mask(
    input logic [N_IN*FUNC_W-1:0] fv,
    input ifc_func_type f
  );
    logic [N_IN-1:0] m;
    m = '0;
    for (int i = 0; i < N_IN; i++) begin
      m[i] = (fv[i*FUNC_W +: FUNC_W] == f);
    end
    return m;
  endfunction

  // more than one input carries the function
  function automatic logic fn_multi(
    input logic [N_IN*FUNC_W-1:0] fv,
    input ifc_func_type f
  );
    logic [N_IN-1:0] m;
    m = fn_mask(fv, f);
    return (m & (m - 1'b1)) != '0;
  endfunction

  wire [N_IN-1:0] en_mask = fn_mask(func_flat, FN_ENABLE);
  wire [N_IN-1:0] uv_mask = fn_mask(func_flat, FN_UV_SEL);
  wire [N_IN-1:0] bc_mask = fn_mask(func_flat, FN_BUS_CONN);
  wire has_start = |fn_mask(func_flat, FN_START);
  wire has_stop_fclr = |fn_mask(func_flat, FN_STOP_FCLR);
  wire has_run = |fn_mask(func_flat, FN_RUN);
  wire has_run_f = |fn_mask(func_flat, FN_RUN_FWD);
  wire has_run_r = |fn_mask(func_flat, FN_RUN_REV);
  wire has_jog = |fn_mask(func_flat, FN_JOG);
  wire has_jog_f = |fn_mask(func_flat, FN_JOG_FWD);
  wire has_jog_r = |fn_mask(func_flat, FN_JOG_REV);
  wire has_fr = |fn_mask(func_flat, FN_FWD_REV);
  wire has_pair = |fn_mask(func_flat, FN_PAIRED_RAMP);
  wire has_acc2 = |fn_mask(func_flat, FN_ACC2);
  wire has_dec2 = |fn_mask(func_flat, FN_DEC2);
  wire has_jog_dir = has_jog_f | has_jog_r;
  wire has_run_dir = has_run_f | has_run_r;

  // ----------------------------------------------------------------
  // conflict alarms, combinational from config each cycle
  // ----------------------------------------------------------------
  wire cf_a = (has_pair && (has_acc2 || has_dec2))
    || (has_jog && has_jog_dir)
    || (has_jog_dir && has_fr)
    || (has_start && !has_stop_fclr);

  wire cf_b = ((has_start || has_run)
      && (has_run_dir || has_jog_dir))
    || (has_run_dir && (has_jog || has_fr));

  wire cf_c = fn_multi(func_flat, FN_FWD_REV)
    || fn_multi(func_flat, FN_SPD_SEL1) || fn_multi(func_flat, FN_SPD_SEL2)
    || fn_multi(func_flat, FN_SPD_SEL3) || fn_multi(func_flat, FN_RUN)
    || fn_multi(func_flat, FN_RUN_FWD) || fn_multi(func_flat, FN_RUN_REV)
    || fn_multi(func_flat, FN_JOG_FWD) || fn_multi(func_flat, FN_JOG_REV)
    || fn_multi(func_flat, FN_STOP_B) || fn_multi(func_flat, FN_BUSREG_B)
    || fn_multi(func_flat, FN_PAIRED_RAMP)
    || fn_multi(func_flat, FN_ACC2) || fn_multi(func_flat, FN_DEC2);

  wire dir_fn = has_fr || has_run_dir || has_jog_dir;
  wire cf_bip = dir_fn && (dir_mode_q != DIR_TERMINAL);
  wire any_cf = cf_a || cf_b || cf_c || cf_bip;

  assign alarm = '{general: cf_a, start_mode: cf_b,
                   duplicate: cf_c, bipolar: cf_bip};

  // ----------------------------------------------------------------
  // permissives
  // ----------------------------------------------------------------
  // any configured permissive input that is open blocks
  wire enable_ok = ((en_mask & ~pin_sync_q) == '0);
  // no bus-connect input means permanently connected
  wire bus_conn = ((bc_mask & ~pin_sync_q) == '0);
  wire start_ok = enable_ok && bus_conn && !any_cf;

  // ----------------------------------------------------------------
  // run sequencing
  // ----------------------------------------------------------------
  logic run_q;
  logic not_en_q;
  logic rev_q;
  wire start_req = wr_ctrl && reg_wdata[CTRL_START];
  wire stop_req = wr_ctrl && reg_wdata[CTRL_STOP];
  wire want_rev = wr_ctrl && reg_wdata[CTRL_REV];
  // direction policy decides reverse
  wire rev_next = (dir_mode_q == DIR_REV_DIS) ? 1'b0 :
                  (dir_mode_q == DIR_BIPOLAR) ? ref_negative : want_rev;

  // coast on lost permissive, no fault raised
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= 1'b0;
      not_en_q <= 1'b0;
      rev_q <= 1'b0;
    end else begin
      if (run_q && (!enable_ok || !bus_conn || stop_req)) begin
        run_q <= 1'b0;
      end else if (!run_q && start_req && start_ok) begin
        run_q <= 1'b1;
        rev_q <= rev_next;
      end else if (run_q && dir_mode_q == DIR_BIPOLAR) begin
        rev_q <= ref_negative;
      end
      not_en_q <= !enable_ok;
    end
  end

  assign motor_run = run_q;
  assign motor_rev = run_q && rev_q && (dir_mode_q != DIR_REV_DIS);
  assign coast_stop = run_q && (!enable_ok || !bus_conn);
  assign not_enabled = not_en_q;
  assign precharge_relay = bus_conn; // open when disconnected

  // ready and operator indications follow the alarm set
  assign drive_ready = !any_cf && enable_ok && bus_conn;
  assign panel_conflict_msg = any_cf;

  logic [3:0] flash_q;
  // slow divider keeps the flashing visible
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_q <= '0;
    end else begin
      flash_q <= flash_q + 4'h1;
    end
  end
  assign led_flash_yellow = any_cf && flash_q[3];

  // ----------------------------------------------------------------
  // undervoltage threshold
  // ----------------------------------------------------------------
  // unassigned select falls back to internal level
  wire use_set = (uv_mask != '0) && ((uv_mask & pin_sync_q) != '0);
  wire [BUS_W-1:0] uv_thr = use_set ? uv_level_q : UV_INTERNAL;
  logic ploss_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ploss_q <= 1'b0;
    end else begin
      ploss_q <= bus_level < uv_thr;
    end
  end
  assign power_loss = ploss_q;

  // ----------------------------------------------------------------
  // relay outputs
  // ----------------------------------------------------------------
  // link follows input even when it has another function
  // unused input gives a dead link
  generate
    for (gi = 0; gi < NUM_OUT; gi++) begin : g_relay
      wire [SEL_W-1:0] sel = out_sel_q[gi];
      wire [SEL_W-1:0] idx = sel - SEL_LINK0;
      wire is_link = (sel >= SEL_LINK0) && (idx < SEL_W'(N_IN));
      wire [2:0] ix3 = idx[2:0];
      wire link_val = is_link && (func_q[ix3] != FN_UNUSED)
        && pin_sync_q[ix3];
      logic rly_q;
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          rly_q <= 1'b0;
        end else begin
          rly_q <= (sel == SEL_RUN) ? run_q : link_val;
        end
      end
      assign relay_out[gi] = rly_q;
    end
  endgenerate

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  wire [ST_W-1:0] status_w = {motor_rev, !bus_conn, ploss_q, cf_bip,
    cf_c, cf_b, cf_a, not_en_q, drive_ready, run_q};

  logic [31:0] rd_mux;
  // unmapped offsets read zero
  always_comb begin
    rd_mux = '0;
    case (reg_addr)
      REG_IN_CFG0: begin
        for (int i = 0; i < 4 && i < N_IN; i++) begin
          rd_mux[i*8 +: FUNC_W] = func_q[i];
        end
      end
      REG_IN_CFG1: begin
        for (int i = 4; i < N_IN; i++) begin
          rd_mux[(i-4)*8 +: FUNC_W] = func_q[i];
        end
      end
      REG_OUT_SEL: begin
        for (int i = 0; i < NUM_OUT; i++) begin
          rd_mux[i*8 +: SEL_W] = out_sel_q[i];
        end
      end
      REG_DIR_MODE: rd_mux[1:0] = dir_mode_q;
      REG_UV_LEVEL: rd_mux[BUS_W-1:0] = uv_level_q;
      REG_PIN_STATE: rd_mux[N_IN-1:0] = pin_sync_q;
      REG_STATUS: rd_mux[ST_W-1:0] = status_w;
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_start_permit: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (!run_q && !start_ok) |=> !run_q)
    else $error("start taken without permissive");

  chk_enable_coast: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (run_q && !enable_ok) |=> (!run_q && not_en_q))
    else $error("open permissive did not coast");

  chk_any_open: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    ((en_mask & ~pin_sync_q) != '0) |-> !drive_ready)
    else $error("open permissive left ready");

  chk_bus_open: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    ((bc_mask & ~pin_sync_q) != '0) |-> !precharge_relay)
    else $error("precharge relay closed while disconnected");

  chk_conflict_ready: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    any_cf |-> (!drive_ready && panel_conflict_msg))
    else $error("conflict did not clear ready");

  chk_start_missing: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (has_start && !has_stop_fclr) |-> alarm.general)
    else $error("start without stop-clear not flagged");

  chk_dup_run: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    fn_multi(func_flat, FN_RUN) |-> alarm.duplicate)
    else $error("duplicate run not flagged");

  chk_no_reverse: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (dir_mode_q == DIR_REV_DIS) |-> !motor_rev)
    else $error("reverse while blocked");

  chk_pin_status: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == REG_PIN_STATE)
      |=> (reg_rdata[N_IN-1:0] == $past(pin_sync_q)))
    else $error("pin state read mismatch");

endmodule

// ### dv/ifc_contacts.sv
/*
  Contact input model: terminal block switches and wiring.
  Assumes the bench commands wanted states on the core clock.
*/
`timescale 1ns/100ps
module ifc_contacts
  import ifc_pkg::*;
(
  input wire logic core_clk,
  input wire logic [NUM_IN-1:0] want,
  output logic [NUM_IN-1:0] pin_in
);
  // contacts move a little after an edge, never on it
  initial pin_in = '0;
  always @(posedge core_clk) begin
    pin_in <= #3 want;
  end
endmodule

// ### dv/testbench.sv
/*
  Self-checking bench for the digital input supervisor.
  Assumes the contact model and the supervisor core compile first.
*/
`timescale 1ns/100ps
module testbench;
  import ifc_pkg::*;
  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [NUM_IN-1:0] want = '0;
  logic [NUM_IN-1:0] pin_in;
  logic [BUS_W-1:0] bus_level = 12'hfff;
  logic ref_negative = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, d, r;
  logic motor_run, motor_rev, coast_stop, not_enabled, drive_ready;
  logic panel_conflict_msg, led_flash_yellow, power_loss;
  logic precharge_relay;
  logic [NUM_OUT-1:0] relay_out;
  ifc_alarm_type alarm;
  int fails = 0;
  int n_tests = 0;
  int ones;
  logic [BUS_W-1:0] lvl;
  ifc_func_type fa [17] = '{FN_ACC2, FN_DEC2, FN_JOG, FN_JOG_REV,
    FN_START, FN_START, FN_START, FN_RUN, FN_RUN_FWD, FN_RUN_REV,
    FN_SPD_SEL2, FN_STOP_B, FN_ENABLE, FN_JOG_FWD, FN_FWD_REV,
    FN_RUN_FWD, FN_RUN};
  ifc_func_type fb [17] = '{FN_PAIRED_RAMP, FN_PAIRED_RAMP, FN_JOG_FWD,
    FN_FWD_REV, FN_UNUSED, FN_STOP_FCLR, FN_RUN_REV, FN_JOG_REV, FN_JOG,
    FN_FWD_REV, FN_SPD_SEL2, FN_STOP_B, FN_ENABLE, FN_UNUSED,
    FN_UNUSED, FN_UNUSED, FN_RUN};
  logic [3:0] ex [17] = '{4'h8, 4'h8, 4'h8, 4'h8, 4'h8, 4'h0, 4'hc,
    4'h4, 4'h4, 4'h4, 4'h2, 4'h2, 4'h0, 4'h1, 4'h1, 4'h0, 4'h2};
  logic [1:0] dm [17] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0,
    2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h0, 2'h0};

  // clock at 40 MHz
  always #12.5 core_clk = ~core_clk;

  ifc_contacts contacts (.core_clk(core_clk), .want(want),
    .pin_in(pin_in));

  ifc_supervisor dut (.core_clk(core_clk), .rst_n(rst_n),
    .pin_in(pin_in), .bus_level(bus_level), .ref_negative(ref_negative),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .motor_run(motor_run),
    .motor_rev(motor_rev), .coast_stop(coast_stop),
    .not_enabled(not_enabled), .drive_ready(drive_ready),
    .panel_conflict_msg(panel_conflict_msg),
    .led_flash_yellow(led_flash_yellow), .power_loss(power_loss),
    .precharge_relay(precharge_relay), .relay_out(relay_out),
    .alarm(alarm));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // expected power loss from level, settable level and selection
  function automatic logic exp_pl(input logic [11:0] v,
                                  input logic [11:0] s, input logic u);
    return v < (u ? s : UV_INTERNAL);
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  // waits n edges, then samples 1 ns later when outputs settled
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 0;
    #1;
    v = reg_rdata;
  endtask

  task automatic cfg(input ifc_func_type a, b, c, e, f, g);
    wr(REG_IN_CFG0, {3'h0, e, 3'h0, c, 3'h0, b, 3'h0, a});
    wr(REG_IN_CFG1, {19'h0, g, 3'h0, f});
  endtask

  // contacts need two sync edges plus settling
  task automatic pins(input logic [5:0] v);
    @(posedge core_clk);
    want <= v;
    cyc(6);
  endtask

  task automatic go(input logic [31:0] c);
    wr(REG_CTRL, c);
    cyc(2);
  endtask

  task automatic test_done;
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // watchdog at 20000 cycles, far above the fewer than a thousand cycles the run needs
  initial begin
    #(25 * 20000);
    fails++;
    test_done;
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    r = 32'h7756;
    repeat (10) @(posedge core_clk);
    rst_n <= 1;
    rd(REG_STATUS, d);
    chk(d, 32'h2);
    for (int i = 0; i < 8; i++) begin
      r = lfsr(r);
      pins(r[5:0]);
      rd(REG_PIN_STATE, d);
      chk(d, {26'h0, r[5:0]});
    end
    wr(REG_PIN_STATE, 32'h0);
    rd(REG_PIN_STATE, d);
    chk(d, {26'h0, r[5:0]});
    rd(4'hf, d);
    chk(d, 32'h0);
    $display("status word test done");
    // two permissives, link relays to enable, excl and unused input
    cfg(FN_ENABLE, FN_ENABLE, FN_EXCL_LINK, FN_UNUSED, FN_UNUSED,
        FN_UNUSED);
    wr(REG_OUT_SEL, {8'h0, 3'h0, SEL_LINK0 + 5'h3, 3'h0,
        SEL_LINK0 + 5'h2, 3'h0, SEL_LINK0});
    pins(6'b001001);
    go(32'h1);
    chk(motor_run, 1'b0);
    chk(relay_out, 3'b001);
    chk({precharge_relay, alarm}, 5'h10);
    pins(6'b001111);
    go(32'h1);
    chk({motor_run, not_enabled}, 2'b10);
    chk(relay_out, 3'b011);
    @(posedge core_clk);
    want <= 6'b001101;
    cyc(1);
    chk(motor_run, 1'b1);
    cyc(2);
    chk({motor_run, coast_stop}, 2'b11);
    cyc(4);
    chk({motor_run, not_enabled, alarm}, 6'h10);
    go(32'h2);
    $display("permissive and link test done");
    // undervoltage level: unassigned, selected closed, selected open
    wr(REG_UV_LEVEL, 32'h400);
    for (int k = 0; k < 3; k++) begin
      cfg(FN_UNUSED, FN_UNUSED, FN_UNUSED, (k > 0) ? FN_UV_SEL : FN_UNUSED,
          FN_UNUSED, FN_UNUSED);
      pins((k == 2) ? 6'h0 : 6'h8);
      for (int i = 0; i < 8; i++) begin
        r = lfsr(r);
        lvl = (i == 0) ? UV_INTERNAL : (i == 1) ? 12'h3ff : r[11:0];
        @(posedge core_clk);
        bus_level <= lvl;
        cyc(3);
        chk(power_loss, exp_pl(lvl, 12'h400, k == 1));
      end
    end
    bus_level <= 12'hfff;
    $display("power loss test done");
    // bus connect assigned, then unassigned
    cfg(FN_UNUSED, FN_UNUSED, FN_BUS_CONN, FN_UNUSED, FN_UNUSED,
        FN_UNUSED);
    pins(6'b000100);
    go(32'h1);
    chk({motor_run, precharge_relay}, 2'b11);
    pins(6'b000000);
    chk({motor_run, precharge_relay, drive_ready}, 3'b000);
    cfg(FN_UNUSED, FN_UNUSED, FN_UNUSED, FN_UNUSED, FN_UNUSED, FN_UNUSED);
    cyc(2);
    chk({precharge_relay, drive_ready}, 2'b11);
    go(32'h1);
    chk(motor_run, 1'b1);
    go(32'h2);
    $display("bus connect test done");
    // direction policy
    wr(REG_DIR_MODE, 32'h1);
    ref_negative <= 1;
    go(32'h1);
    chk({motor_run, motor_rev}, 2'b11);
    go(32'h2);
    wr(REG_DIR_MODE, 32'h2);
    go(32'h5);
    chk({motor_run, motor_rev}, 2'b10);
    go(32'h2);
    // terminal policy takes reverse from the start command
    wr(REG_DIR_MODE, 32'h0);
    go(32'h5);
    chk({motor_run, motor_rev}, 2'b11);
    go(32'h2);
    $display("direction test done");
    // conflict table: pairs on inputs 4 and 5, both held closed so
    // that a doubled permissive leaves the drive ready
    pins(6'h30);
    for (int i = 0; i < 17; i++) begin
      wr(REG_DIR_MODE, {30'h0, dm[i]});
      cfg(FN_UNUSED, FN_UNUSED, FN_UNUSED, FN_UNUSED, fa[i], fb[i]);
      cyc(2);
      chk(alarm, ex[i]);
      if (ex[i] != 4'h0) begin
        go(32'h1);
        chk({motor_run, drive_ready}, 2'b00);
        chk(panel_conflict_msg, 1'b1);
        ones = 0;
        for (int j = 0; j < 16; j++) begin
          cyc(1);
          ones += led_flash_yellow;
        end
        chk(ones, 8);
      end else begin
        chk({drive_ready, panel_conflict_msg}, 2'b10);
      end
    end
    wr(REG_DIR_MODE, 32'h0);
    cfg(FN_UNUSED, FN_UNUSED, FN_UNUSED, FN_UNUSED, FN_UNUSED, FN_UNUSED);
    cyc(2);
    chk({alarm, drive_ready}, 5'h01);
    go(32'h1);
    chk(motor_run, 1'b1);
    $display("conflict test done");
    test_done;
  end
endmodule
